// ===== hw/lfs_pkg.sv
// lfs_pkg: constants shared by the led channel fault supervisor
// assumes a 100 MHz system clock and comparator flags from analog monitors
package lfs_pkg;

    localparam int NUM_CH = 6;

    // configuration byte fields
    localparam int CFG_SHORT_SEL_LSB = 0;
    localparam int CFG_SHORT_SEL_W = 2;
    localparam int CFG_SHORT_EN_BIT = 3;
    // reset value: short detect on, selection code 2'b11 stands for the default level
    localparam logic [7:0] CFG_RESET = 8'h0b;
    localparam logic [1:0] SHORT_SEL_DEFAULT = 2'h3;

    // fault/status byte fields
    localparam int STAT_THERMAL_BIT = 1;
    localparam int STAT_OPEN_BIT = 2;
    localparam int STAT_SHORT_BIT = 3;
    localparam int STAT_OVERV_BIT = 4;
    localparam int STAT_UNDERV_BIT = 5;
    localparam int STAT_OUTSHORT_BIT = 6;

    // open-circuit time-outs
    localparam int OPEN_TIMEOUT_PWM_CYCLES = 6;
    localparam int HOT_TIMEOUT_US = 800;
    localparam int CLOCK_MHZ = 100;
    localparam int HOT_TIMEOUT_CYCLES = HOT_TIMEOUT_US * CLOCK_MHZ;

    // derating steps: 100, 75, 50, 25 percent
    localparam int DERATE_STEPS = 4;

    typedef enum logic [1:0] {LFS_CH_IDLE, LFS_CH_GOOD, LFS_CH_OPEN, LFS_CH_OFF} lfs_ch_state_t;

    typedef enum logic [2:0] {
        LFS_PWR_OFF,
        LFS_PWR_PROBE,
        LFS_PWR_RUN,
        LFS_PWR_HOT,
        LFS_PWR_LOCK,
        LFS_PWR_DEAD
    } lfs_pwr_state_t;

endpackage

// ===== hw/lfs_sync.sv
// lfs_sync: two flip-flop synchroniser for a bus of asynchronous levels
// assumes the inputs are quasi-static comparator or pin levels
`timescale 1ns/1ps
module lfs_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// ===== hw/lfs_channel.sv
// lfs_channel: classification and time-out of one led current-sink channel
// assumes synchronised comparator flags and a one-cycle pwm start pulse
`timescale 1ns/1ps
module lfs_channel (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // control
    input wire logic clear_i,
    input wire logic masked_i,
    input wire logic short_en_i,
    input wire logic drive_i,
    // monitors
    input wire logic at_target_i,
    input wire logic over_short_i,
    input wire logic force_open_i,
    input wire logic hot_i,
    input wire logic pwm_start_i,
    input wire logic tick_hot_i,
    // state
    output logic good_o,
    output logic open_o,
    output logic off_o,
    output logic short_fault_o,
    output logic open_fault_o
);

    lfs_pkg::lfs_ch_state_t state_q;
    logic [2:0] count_q;
    logic expire;

    assign expire = hot_i ? tick_hot_i
                          : (pwm_start_i && count_q == 3'(lfs_pkg::OPEN_TIMEOUT_PWM_CYCLES - 1));

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= lfs_pkg::LFS_CH_IDLE;
            short_fault_o <= 1'b0;
            open_fault_o <= 1'b0;
        end
        // cleared only by reset, lockout or enable low
        else if (clear_i)
        begin
            state_q <= lfs_pkg::LFS_CH_IDLE;
            short_fault_o <= 1'b0;
            open_fault_o <= 1'b0;
        end
        else if (masked_i || !drive_i || state_q == lfs_pkg::LFS_CH_OFF)
        begin
            state_q <= state_q;
        end
        // short disables now; below threshold stays on
        else if (short_en_i && over_short_i)
        begin
            state_q <= lfs_pkg::LFS_CH_OFF;
            short_fault_o <= 1'b1;
        end
        else
        begin
            unique case (state_q)
                lfs_pkg::LFS_CH_IDLE:
                begin
                    if (at_target_i)
                        state_q <= lfs_pkg::LFS_CH_GOOD;
                    else if (force_open_i)
                        state_q <= lfs_pkg::LFS_CH_OPEN;
                end
                lfs_pkg::LFS_CH_GOOD:
                begin
                    // good falling below target; zener string stays good
                    if (!at_target_i)
                        state_q <= lfs_pkg::LFS_CH_OPEN;
                end
                lfs_pkg::LFS_CH_OPEN:
                begin
                    if (expire)
                    begin
                        state_q <= lfs_pkg::LFS_CH_OFF;
                        open_fault_o <= 1'b1;
                    end
                end
                lfs_pkg::LFS_CH_OFF:
                begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            count_q <= 3'h0;
        else if (state_q != lfs_pkg::LFS_CH_OPEN || clear_i)
            count_q <= 3'h0;
        else if (pwm_start_i)
            count_q <= count_q + 3'h1;
    end

    assign good_o = (state_q == lfs_pkg::LFS_CH_GOOD);
    assign open_o = (state_q == lfs_pkg::LFS_CH_OPEN);
    assign off_o = (state_q == lfs_pkg::LFS_CH_OFF);

    a_short_needs_en: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(short_fault_o) && !$past(clear_i) |-> $past(short_en_i) && $past(over_short_i))
        else $error("short fault without enabled detection");

    // never disabled before six pwm starts when cool
    a_open_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(open_fault_o) && !$past(hot_i) |-> $past(count_q) == 3'h5)
        else $error("open disable before time-out");

endmodule

// ===== hw/lfs_top.sv
// lfs_top: fault supervisor for a six-channel led backlight driver
// assumes comparator flags from analog monitors, pwm cycle pulse level and enable pin,
// all asynchronous to clock_i; config and mask bytes come from a serial slave elsewhere
//
// Function
// - two-bit config field at bits 1:0 picks one of four short thresholds.
// - after reset the short threshold selection is the default level.
// - config bit disables short detection; then no channel is disabled as shorted.
// - with detection on, a channel flagged over short threshold is disabled.
// - a channel reaching its target current is marked good.
// - a good channel falling below target becomes open-circuit.
// - output overvoltage or lower overtemp makes every idle channel below target open-circuit.
// - an open channel is disabled after a six pwm cycle time-out.
// - while above lower overtemp, the time-out ends at the next tick of a free 800 us window.
// - input undervoltage lock stops boost switching and resets control logic.
// - under serial control, stay off after lockout until host re-enables.
// - without serial control, restart after lockout clears if already enabled.
// - at start-up inject test current; no switching until switch node level exceeded.
// - output sense rising above then falling below 20 percent turns off input fet.
// - each upper overtemp trip stops boost and turns off all current sources.
// - after cooling restart derated, stepping through 75, 50 then 25 percent.
// - an upper overtemp trip sets the thermal fault status bit.
// - during thermal shutdown the control logic stays active unless enable low.
// - a zener-bypassed open string stays on unless overvoltage is reached.
// - a shorted channel below the channel level stays on, others normal.
// - faults of all unmasked led channels are recorded in the fault/status register.
// - masked channels are not driven and not reported as faults.
`timescale 1ns/1ps
module lfs_top (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // configuration from the serial register file
    input wire logic [7:0] config_i,
    input wire logic [5:0] mask_i,
    input wire logic serial_mode_i,
    input wire logic serial_enable_i,
    // pins and analog comparator flags
    input wire logic enable_pin_i,
    input wire logic pwm_cycle_i,
    input wire logic [5:0] at_target_i,
    input wire logic [5:0] over_short_i,
    input wire logic output_overvoltage_i,
    input wire logic input_undervoltage_lock_i,
    input wire logic temp_lower_i,
    input wire logic temp_upper_i,
    input wire logic temp_cooled_i,
    input wire logic switch_node_ok_i,
    input wire logic sense_above_frac_i,
    // power stage control
    output logic boost_run_o,
    output logic test_current_o,
    output logic input_fet_on_o,
    output logic [5:0] sink_on_o,
    output logic [1:0] short_sel_o,
    output logic [1:0] derate_step_o,
    // status
    output logic [7:0] fault_status_o,
    output logic [5:0] ch_good_o,
    output logic [5:0] ch_off_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // reset and input synchronisation

    logic rst_a_q;
    logic rst_n;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_a_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_a_q <= 1'b1;
            rst_n <= rst_a_q;
        end
    end

    localparam int SYNC_W = 21;
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_in;
    logic en_pin;
    logic pwm_lvl;
    logic [5:0] tgt;
    logic [5:0] ovs;
    logic output_overvoltage;
    logic uvl;
    logic t_lo;
    logic t_hi;
    logic t_cool;
    logic sw_ok;
    logic sense_hi;

    assign raw_in = {enable_pin_i, pwm_cycle_i, at_target_i, over_short_i, output_overvoltage_i,
                     input_undervoltage_lock_i, temp_lower_i, temp_upper_i, temp_cooled_i,
                     switch_node_ok_i, sense_above_frac_i};

    lfs_sync #(.W(SYNC_W)) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .async_i(raw_in),
        .sync_o(sync_in)
    );

    assign {en_pin, pwm_lvl, tgt, ovs, output_overvoltage, uvl, t_lo, t_hi, t_cool, sw_ok, sense_hi} = sync_in;

    ////////////////////////////////////////////////////////////////////////////////
    // pwm cycle start and hot time-out tick

    logic pwm_prev_q;
    logic pwm_start;
    logic [16:0] hot_cnt_q;
    logic hot_tick;

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            pwm_prev_q <= 1'b0;
        else
            pwm_prev_q <= pwm_lvl;
    end

    assign pwm_start = pwm_lvl && !pwm_prev_q;

    // free 800 us window, restarted when cool so the first window is whole
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            hot_cnt_q <= 17'h0;
        else if (!t_lo || hot_tick)
            hot_cnt_q <= 17'h0;
        else
            hot_cnt_q <= hot_cnt_q + 17'h1;
    end

    assign hot_tick = (hot_cnt_q == 17'(lfs_pkg::HOT_TIMEOUT_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////////
    // power sequencing

    lfs_pkg::lfs_pwr_state_t pwr_q;
    logic enabled;
    logic lockout_clear;
    logic uvl_hold_q;
    logic sense_armed_q;
    logic [1:0] derate_q;
    logic thermal_q;
    logic outshort_q;
    logic uvl_seen_q;

    // serial mode waits for a fresh enable; pin mode restarts on its own
    assign enabled = en_pin && (serial_mode_i ? (serial_enable_i && !uvl_hold_q) : 1'b1);
    // lockout resets the channel and derate state
    assign lockout_clear = uvl || !en_pin;

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            uvl_hold_q <= 1'b0;
        // hold off until host drops and rewrites its enable
        else if (uvl)
            uvl_hold_q <= 1'b1;
        else if (!serial_enable_i)
            uvl_hold_q <= 1'b0;
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            pwr_q <= lfs_pkg::LFS_PWR_OFF;
        else if (uvl)
            pwr_q <= lfs_pkg::LFS_PWR_LOCK;
        // enable low shuts everything, else logic stays alive
        else if (!en_pin)
            pwr_q <= lfs_pkg::LFS_PWR_OFF;
        else
        begin
            unique case (pwr_q)
                lfs_pkg::LFS_PWR_OFF,
                lfs_pkg::LFS_PWR_LOCK:
                    if (enabled)
                        pwr_q <= lfs_pkg::LFS_PWR_PROBE;
                // wait for switch node before switching
                lfs_pkg::LFS_PWR_PROBE:
                    if (sw_ok)
                        pwr_q <= lfs_pkg::LFS_PWR_RUN;
                lfs_pkg::LFS_PWR_RUN:
                begin
                    // output collapsed after rising: latch off
                    if (sense_armed_q && !sense_hi)
                        pwr_q <= lfs_pkg::LFS_PWR_DEAD;
                    // upper trip stops boost and sinks
                    else if (t_hi)
                        pwr_q <= lfs_pkg::LFS_PWR_HOT;
                    else if (!enabled)
                        pwr_q <= lfs_pkg::LFS_PWR_OFF;
                end
                lfs_pkg::LFS_PWR_HOT:
                    if (t_cool && !t_hi)
                        pwr_q <= lfs_pkg::LFS_PWR_RUN;
                lfs_pkg::LFS_PWR_DEAD:
                    pwr_q <= pwr_q;
            endcase
        end
    end

    // arm once the sense node has risen above the fraction
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            sense_armed_q <= 1'b0;
        else if (pwr_q != lfs_pkg::LFS_PWR_RUN && pwr_q != lfs_pkg::LFS_PWR_HOT)
            sense_armed_q <= 1'b0;
        else if (sense_hi)
            sense_armed_q <= 1'b1;
    end

    // step derating per trip; cleared only by reset or lockout
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            derate_q <= 2'h0;
        else if (uvl)
            derate_q <= 2'h0;
        else if (pwr_q == lfs_pkg::LFS_PWR_RUN && t_hi && derate_q != 2'(lfs_pkg::DERATE_STEPS - 1))
            derate_q <= derate_q + 2'h1;
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            thermal_q <= 1'b0;
        else if (uvl)
            thermal_q <= 1'b0;
        else if (pwr_q == lfs_pkg::LFS_PWR_RUN && t_hi)
            thermal_q <= 1'b1;
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            outshort_q <= 1'b0;
            uvl_seen_q <= 1'b0;
        end
        else
        begin
            if (pwr_q == lfs_pkg::LFS_PWR_RUN && sense_armed_q && !sense_hi)
                outshort_q <= 1'b1;
            if (uvl)
                uvl_seen_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // channels

    logic [5:0] ch_good;
    logic [5:0] ch_open;
    logic [5:0] ch_off;
    logic [5:0] ch_short_f;
    logic [5:0] ch_open_f;
    logic running;
    logic short_en;

    assign running = (pwr_q == lfs_pkg::LFS_PWR_RUN);
    assign short_en = config_i[lfs_pkg::CFG_SHORT_EN_BIT];

    for (genvar i = 0; i < lfs_pkg::NUM_CH; i++)
    begin : g_ch
        lfs_channel u_ch (
            .clock_i(clock_i),
            .rst_n_i(rst_n),
            .clear_i(lockout_clear),
            .masked_i(mask_i[i]),
            .short_en_i(short_en),
            .drive_i(running),
            .at_target_i(tgt[i]),
            .over_short_i(ovs[i]),
            .force_open_i(output_overvoltage || t_lo),
            .hot_i(t_lo),
            .pwm_start_i(pwm_start),
            .tick_hot_i(hot_tick),
            .good_o(ch_good[i]),
            .open_o(ch_open[i]),
            .off_o(ch_off[i]),
            .short_fault_o(ch_short_f[i]),
            .open_fault_o(ch_open_f[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered outputs

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boost_run_o <= 1'b0;
            test_current_o <= 1'b0;
            input_fet_on_o <= 1'b0;
            sink_on_o <= 6'h00;
            short_sel_o <= lfs_pkg::SHORT_SEL_DEFAULT;
            derate_step_o <= 2'h0;
            fault_status_o <= 8'h00;
            ch_good_o <= 6'h00;
            ch_off_o <= 6'h00;
        end
        else
        begin
            boost_run_o <= running;
            test_current_o <= (pwr_q == lfs_pkg::LFS_PWR_PROBE);
            input_fet_on_o <= (pwr_q != lfs_pkg::LFS_PWR_DEAD) && (pwr_q != lfs_pkg::LFS_PWR_OFF)
                              && (pwr_q != lfs_pkg::LFS_PWR_LOCK);
            // sinks off when hot, masked or disabled
            sink_on_o <= running ? (~mask_i & ~ch_off) : 6'h00;
            // threshold select passes to the analog comparators
            short_sel_o <= config_i[lfs_pkg::CFG_SHORT_SEL_LSB +: lfs_pkg::CFG_SHORT_SEL_W];
            derate_step_o <= derate_q;
            fault_status_o <= 8'h00;
            fault_status_o[lfs_pkg::STAT_THERMAL_BIT] <= thermal_q;
            fault_status_o[lfs_pkg::STAT_OPEN_BIT] <= |(ch_open_f & ~mask_i);
            fault_status_o[lfs_pkg::STAT_SHORT_BIT] <= |(ch_short_f & ~mask_i);
            fault_status_o[lfs_pkg::STAT_OVERV_BIT] <= output_overvoltage;
            fault_status_o[lfs_pkg::STAT_UNDERV_BIT] <= uvl_seen_q;
            fault_status_o[lfs_pkg::STAT_OUTSHORT_BIT] <= outshort_q;
            ch_good_o <= ch_good;
            ch_off_o <= ch_off & ~mask_i;
        end
    end

    // upper trip kills boost and sinks within two cycles
    a_hot_stops_all: assert property (@(posedge clock_i) disable iff (!rst_n)
        pwr_q == lfs_pkg::LFS_PWR_RUN && t_hi && en_pin && !uvl && !(sense_armed_q && !sense_hi)
        |=> ##1 !boost_run_o && sink_on_o == 6'h00)
        else $error("boost still on after upper trip");

    // no switching until the switch node is proven
    a_probe_first: assert property (@(posedge clock_i) disable iff (!rst_n)
        $rose(boost_run_o) |-> $past(sw_ok, 2) || $past(pwr_q == lfs_pkg::LFS_PWR_HOT, 2))
        else $error("boost started without switch node check");

    a_uvl_stops: assert property (@(posedge clock_i) disable iff (!rst_n)
        uvl |=> ##1 !boost_run_o)
        else $error("switching during undervoltage lock");

    // trip sets thermal bit two cycles on
    a_thermal_flag: assert property (@(posedge clock_i) disable iff (!rst_n)
        running && t_hi && !uvl |=> ##1 fault_status_o[lfs_pkg::STAT_THERMAL_BIT])
        else $error("thermal bit not set");

    a_mask_no_sink: assert property (@(posedge clock_i) disable iff (!rst_n)
        (sink_on_o & $past(mask_i)) == 6'h00)
        else $error("masked channel driven");

    // derate never wraps back to full current
    a_derate_mono: assert property (@(posedge clock_i) disable iff (!rst_n)
        !$past(uvl) |-> derate_q >= $past(derate_q))
        else $error("derating stepped back");

endmodule

// ===== testbench/lfs_plant.sv
// lfs_plant: analog model of the output and switch node during the start-up probe
// assumes test_current_i and boost_run_i are the supervisor's registered outputs
`timescale 1ns/1ps
module lfs_plant (
    // clock
    input wire logic clock_i,
    // supervisor outputs
    input wire logic test_current_i,
    input wire logic boost_run_i,
    // comparator
    output logic switch_node_ok_o
);
    logic [4:0] charge_q = 5'h00;

    ////////////////////////////////////////////////////////////////
    // slow output charge
    // the level lags the test current on purpose, so early switching shows
    always_ff @(posedge clock_i)
    begin
        if (!test_current_i && !boost_run_i)
            charge_q <= 5'h00;
        else if (charge_q != 5'h10)
            charge_q <= charge_q + 5'h01;
    end

    assign switch_node_ok_o = (charge_q == 5'h10);
endmodule

// ===== testbench/testbench.sv
// testbench: directed tests of the led channel fault supervisor
// assumes the plant model answers the start-up probe
`timescale 1ns/1ps
module testbench;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] config_i = 8'h0b;
    logic [5:0] mask_i = 6'h00;
    logic serial_mode_i = 1'b0;
    logic serial_enable_i = 1'b0;
    logic enable_pin_i = 1'b0;
    logic pwm_cycle_i = 1'b0;
    logic [5:0] at_target_i = 6'h00;
    logic [5:0] over_short_i = 6'h00;
    logic output_overvoltage_i = 1'b0;
    logic input_undervoltage_lock_i = 1'b0;
    logic temp_lower_i = 1'b0;
    logic temp_upper_i = 1'b0;
    logic temp_cooled_i = 1'b0;
    logic sense_above_frac_i = 1'b0;
    logic switch_node_ok_i;
    logic boost_run_o;
    logic test_current_o;
    logic input_fet_on_o;
    logic [5:0] sink_on_o;
    logic [1:0] short_sel_o;
    logic [1:0] derate_step_o;
    logic [7:0] fault_status_o;
    logic [5:0] ch_good_o;
    logic [5:0] ch_off_o;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    always #5 clock_i = ~clock_i;

    lfs_top lfs_top_i (.clock_i(clock_i), .resetn_i(resetn_i), .config_i(config_i), .mask_i(mask_i),
        .serial_mode_i(serial_mode_i), .serial_enable_i(serial_enable_i), .enable_pin_i(enable_pin_i),
        .pwm_cycle_i(pwm_cycle_i), .at_target_i(at_target_i), .over_short_i(over_short_i),
        .output_overvoltage_i(output_overvoltage_i), .input_undervoltage_lock_i(input_undervoltage_lock_i),
        .temp_lower_i(temp_lower_i), .temp_upper_i(temp_upper_i), .temp_cooled_i(temp_cooled_i),
        .switch_node_ok_i(switch_node_ok_i), .sense_above_frac_i(sense_above_frac_i),
        .boost_run_o(boost_run_o), .test_current_o(test_current_o), .input_fet_on_o(input_fet_on_o),
        .sink_on_o(sink_on_o), .short_sel_o(short_sel_o), .derate_step_o(derate_step_o),
        .fault_status_o(fault_status_o), .ch_good_o(ch_good_o), .ch_off_o(ch_off_o));

    lfs_plant lfs_plant_i (.clock_i(clock_i), .test_current_i(test_current_o), .boost_run_i(boost_run_o),
        .switch_node_ok_o(switch_node_ok_i));

    ////////////////////////////////////////////////////////////////
    task end_of_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wait_cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // pwm pulses are long enough to survive the input synchroniser
    task pulse_pwm(input int n);
        repeat (n)
        begin
            pwm_cycle_i = 1'b1;
            wait_cyc(4);
            pwm_cycle_i = 1'b0;
            wait_cyc(4);
        end
    endtask

    // a hang is cut short well above the expected run length
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        wait_cyc(5);
        check({6'h00, short_sel_o}, 8'h03);
        wait_cyc(5);
        resetn_i = 1'b1;
        wait_cyc(4);
        $display("reset test done");
        enable_pin_i = 1'b1;
        wait_cyc(8);
        check({6'h00, test_current_o, boost_run_o}, 8'h02);
        wait_cyc(24);
        check({7'h00, boost_run_o}, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            config_i = 8'h08 | 8'(i);
            wait_cyc(8);
            check({6'h00, short_sel_o}, 8'(i));
        end
        at_target_i = 6'h3f;
        wait_cyc(8);
        check({2'h0, ch_good_o}, 8'h3f);
        config_i = 8'h03;
        over_short_i = 6'h02;
        wait_cyc(8);
        check({2'h0, ch_off_o}, 8'h00);
        over_short_i = 6'h00;
        wait_cyc(4);
        config_i = 8'h0b;
        over_short_i = 6'h01;
        wait_cyc(8);
        check({2'h0, ch_off_o}, 8'h01);
        check({7'h00, fault_status_o[3]}, 8'h01);
        over_short_i = 6'h00;
        $display("short test done");
        at_target_i = 6'h3b;
        wait_cyc(8);
        check({7'h00, ch_good_o[2]}, 8'h00);
        pulse_pwm(5);
        wait_cyc(8);
        check({7'h00, ch_off_o[2]}, 8'h00);
        pulse_pwm(1);
        wait_cyc(8);
        check({7'h00, ch_off_o[2]}, 8'h01);
        check({7'h00, fault_status_o[2]}, 8'h01);
        $display("open test done");
        for (int i = 1; i < 3; i++)
        begin
            temp_upper_i = 1'b1;
            wait_cyc(8);
            check({1'b0, sink_on_o, boost_run_o}, 8'h00);
            check({7'h00, fault_status_o[1]}, 8'h01);
            temp_upper_i = 1'b0;
            temp_cooled_i = 1'b1;
            wait_cyc(40);
            temp_cooled_i = 1'b0;
            check({5'h00, derate_step_o, boost_run_o}, 8'(i * 2 + 1));
        end
        $display("thermal test done");
        input_undervoltage_lock_i = 1'b1;
        wait_cyc(8);
        check({5'h00, derate_step_o, boost_run_o}, 8'h00);
        check({7'h00, fault_status_o[5]}, 8'h01);
        input_undervoltage_lock_i = 1'b0;
        wait_cyc(40);
        check({7'h00, boost_run_o}, 8'h01);
        $display("lockout test done");
        output_overvoltage_i = 1'b1;
        wait_cyc(8);
        check({7'h00, fault_status_o[4]}, 8'h01);
        output_overvoltage_i = 1'b0;
        pulse_pwm(6);
        wait_cyc(8);
        check({2'h0, ch_off_o}, 8'h04);
        mask_i = 6'h04;
        wait_cyc(2);
        check({1'b0, fault_status_o[2], sink_on_o}, 8'h3b);
        check({2'h0, ch_off_o}, 8'h00);
        $display("forced open test done");
        serial_mode_i = 1'b1;
        serial_enable_i = 1'b1;
        input_undervoltage_lock_i = 1'b1;
        wait_cyc(8);
        input_undervoltage_lock_i = 1'b0;
        wait_cyc(40);
        check({7'h00, boost_run_o}, 8'h00);
        serial_enable_i = 1'b0;
        wait_cyc(4);
        serial_enable_i = 1'b1;
        wait_cyc(40);
        check({7'h00, boost_run_o}, 8'h01);
        $display("serial test done");
        sense_above_frac_i = 1'b1;
        wait_cyc(8);
        check({7'h00, input_fet_on_o}, 8'h01);
        sense_above_frac_i = 1'b0;
        wait_cyc(8);
        check({5'h00, fault_status_o[6], input_fet_on_o, boost_run_o}, 8'h04);
        $display("output short test done");
        end_of_test();
    end
endmodule
